// File: core/psw_pkg.sv
// Purpose: Shared constants for the program status flag logic.
// Assumes: Nibble-wide data memory with 7-bit addresses.
// Notes: Offsets are the data memory addresses of the two status nibbles.
package psw_pkg;
    // =========================================================
    // Addresses
    localparam logic [6:0] PSW_ADDR_PTR_LOW = 7'h7E;
    localparam logic [6:0] PSW_ADDR_FLAGS = 7'h7F;
    // =========================================================
    // Field positions
    localparam int PSW_BIT_DECIMAL = 0;
    localparam int PSW_BIT_INDEX = 0;
    localparam int PSW_BIT_ZERO = 1;
    localparam int PSW_BIT_CARRY = 2;
    localparam int PSW_BIT_COMPARE = 3;
    // =========================================================
    // Reset values
    localparam logic [3:0] PSW_RST_PTR_LOW = 4'h0;
    localparam logic [3:0] PSW_RST_FLAGS = 4'h0;
    // =========================================================
    // Operations
    typedef enum logic [2:0] {
        PSW_OP_NONE = 3'h0,
        PSW_OP_ADD = 3'h1,
        PSW_OP_ADDC = 3'h2,
        PSW_OP_SUB = 3'h3,
        PSW_OP_SUBC = 3'h4,
        PSW_OP_ROTATE = 3'h5,
        PSW_OP_BIT_TEST = 3'h6
    } psw_op_t;
endpackage

// File: core/psw_flag_logic.sv
// Operation
// - Status word: decimal bit at 7EH bit 0, four flags at 7FH.
// - Flag nibble: compare bit 3, carry bit 2, zero bit 1, index bit 0.
// - Reset clears all five bits; interrupt entry saves them to stack.
// - Index enable set applies index modification to data addresses.
// - Compare clear: zero set on zero result, cleared otherwise.
// - Compare set: zero kept on zero result, cleared otherwise.
// - Compare set suppresses arithmetic write-back; only carry and zero update.
// - Zero changes only by arithmetic; compare only by bit tests or writes.
// - A bit test instruction clears the compare flag.
// - Carry set on add carry or subtract borrow, else cleared.
// - Rotate right: old carry into msb, lsb into carry.
// - Carry updated only by arithmetic and rotation, regardless of compare.
// - Decimal flag set selects BCD arithmetic, else 4-bit binary.
// - Decimal flag has no effect on logic, tests or rotations.
// - Arithmetic result stored into the flag nibble overrides flag updates.
// - Fixed-zero bits ignore writes and read as zero.
// - Status nibbles read and write like ordinary data memory.
// - Real address is the data address ORed with the index register.
// - Upper three bits of 7EH hold the general row pointer.
//
// Purpose: Program status word, arithmetic flag update and address modification.
// Assumes: One core clock; execution unit presents one operation per cycle.
// Notes: The datapath computes the nibble result combinationally.
`timescale 1ns/100ps
module psw_flag_logic (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire psw_pkg::psw_op_t op_code,
    input wire logic [3:0] op_a,
    input wire logic [3:0] op_b,
    input wire logic [6:0] op_dest_addr,
    input wire logic [6:0] mem_addr_in,
    input wire logic [6:0] index_register,
    input wire logic mem_wr_en,
    input wire logic [6:0] mem_wr_addr,
    input wire logic [3:0] mem_wr_data,
    input wire logic [6:0] mem_rd_addr,
    input wire logic int_take,
    input wire logic int_restore,
    input wire logic [4:0] int_restore_word,
    output logic [3:0] mem_rd_data,
    output logic mem_rd_hit,
    output logic [3:0] result_ff,
    output logic result_wr_ff,
    output logic [6:0] result_addr_ff,
    output logic [6:0] real_addr,
    output logic [4:0] int_save_word_ff,
    output logic int_save_ff,
    output logic [2:0] general_row_pointer,
    output logic carry_flag,
    output logic zero_flag,
    output logic compare_only_flag,
    output logic index_enable_flag,
    output logic decimal_flag
);
    import psw_pkg::*;

    typedef struct packed {
        logic [2:0] row_ptr;
        logic decimal;
        logic compare;
        logic carry;
        logic zero;
        logic index_en;
        logic [3:0] result;
        logic result_wr;
        logic [6:0] result_addr;
        logic [4:0] save_word;
        logic save;
    } psw_state_t;

    psw_state_t st_ff;
    psw_state_t nxt_st;

    // =========================================================
    // Arithmetic helpers
    // =========================================================
    function automatic logic is_arith(input psw_op_t op);
        is_arith = (op == PSW_OP_ADD) || (op == PSW_OP_ADDC) ||
                   (op == PSW_OP_SUB) || (op == PSW_OP_SUBC);
    endfunction

    logic [4:0] bin_sum;
    logic [3:0] arith_res;
    logic arith_carry;
    logic cin;
    logic sub_op;

    always_comb
    begin
        sub_op = (op_code == PSW_OP_SUB) || (op_code == PSW_OP_SUBC);
        cin = ((op_code == PSW_OP_ADDC) || (op_code == PSW_OP_SUBC)) ? st_ff.carry : 1'b0;
        if (sub_op)
        begin
            bin_sum = {1'b0, op_a} - {1'b0, op_b} - {4'h0, cin};
        end
        else
        begin
            bin_sum = {1'b0, op_a} + {1'b0, op_b} + {4'h0, cin};
        end
        if (st_ff.decimal && !sub_op)
        begin
            arith_carry = bin_sum > 5'h09;
            arith_res = arith_carry ? 4'(bin_sum + 5'h06) : bin_sum[3:0];
        end
        else if (st_ff.decimal)
        begin
            arith_carry = bin_sum[4];
            arith_res = arith_carry ? 4'(bin_sum - 5'h06) : bin_sum[3:0];
        end
        else
        begin
            arith_carry = bin_sum[4];
            arith_res = bin_sum[3:0];
        end
    end

    // =========================================================
    // Next state
    // =========================================================
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.result_wr = 1'b0;
        nxt_st.save = 1'b0;
        if (is_arith(op_code))
        begin
            nxt_st.carry = arith_carry;
            if (arith_res != 4'h0)
            begin
                nxt_st.zero = 1'b0;
            end
            else if (!st_ff.compare)
            begin
                nxt_st.zero = 1'b1;
            end
            nxt_st.result = arith_res;
            nxt_st.result_addr = op_dest_addr;
            nxt_st.result_wr = !st_ff.compare;
            if (!st_ff.compare && op_dest_addr == PSW_ADDR_FLAGS)
            begin
                nxt_st.compare = arith_res[PSW_BIT_COMPARE];
                nxt_st.carry = arith_res[PSW_BIT_CARRY];
                nxt_st.zero = arith_res[PSW_BIT_ZERO];
                nxt_st.index_en = arith_res[PSW_BIT_INDEX];
            end
            else if (!st_ff.compare && op_dest_addr == PSW_ADDR_PTR_LOW)
            begin
                nxt_st.row_ptr = arith_res[3:1];
                nxt_st.decimal = arith_res[PSW_BIT_DECIMAL];
            end
        end
        else if (op_code == PSW_OP_ROTATE)
        begin
            nxt_st.carry = op_a[0];
            nxt_st.result = {st_ff.carry, op_a[3:1]};
            nxt_st.result_addr = op_dest_addr;
            nxt_st.result_wr = 1'b1;
        end
        else if (op_code == PSW_OP_BIT_TEST)
        begin
            nxt_st.compare = 1'b0;
        end
        if (mem_wr_en && mem_wr_addr == PSW_ADDR_FLAGS)
        begin
            nxt_st.compare = mem_wr_data[PSW_BIT_COMPARE];
            nxt_st.carry = mem_wr_data[PSW_BIT_CARRY];
            nxt_st.zero = mem_wr_data[PSW_BIT_ZERO];
            nxt_st.index_en = mem_wr_data[PSW_BIT_INDEX];
        end
        if (mem_wr_en && mem_wr_addr == PSW_ADDR_PTR_LOW)
        begin
            nxt_st.row_ptr = mem_wr_data[3:1];
            nxt_st.decimal = mem_wr_data[PSW_BIT_DECIMAL];
        end
        if (int_take)
        begin
            nxt_st.save = 1'b1;
            nxt_st.save_word = {st_ff.decimal, st_ff.compare, st_ff.carry,
                                st_ff.zero, st_ff.index_en};
        end
        if (int_restore)
        begin
            {nxt_st.decimal, nxt_st.compare, nxt_st.carry,
             nxt_st.zero, nxt_st.index_en} = int_restore_word;
        end
        if (sys_rst)
        begin
            nxt_st = '0;
            {nxt_st.row_ptr, nxt_st.decimal} = PSW_RST_PTR_LOW;
            {nxt_st.compare, nxt_st.carry, nxt_st.zero, nxt_st.index_en} = PSW_RST_FLAGS;
        end
    end

    always_ff @(posedge mclk)
    begin
        st_ff <= nxt_st;
    end

    // =========================================================
    // Outputs
    // =========================================================
    // nibble read layout.
    always_comb
    begin
        mem_rd_hit = 1'b1;
        if (mem_rd_addr == PSW_ADDR_FLAGS)
        begin
            mem_rd_data = {st_ff.compare, st_ff.carry, st_ff.zero, st_ff.index_en};
        end
        else if (mem_rd_addr == PSW_ADDR_PTR_LOW)
        begin
            mem_rd_data = {st_ff.row_ptr, st_ff.decimal};
        end
        else
        begin
            mem_rd_hit = 1'b0;
            mem_rd_data = 4'h0;
        end
    end

    assign real_addr = st_ff.index_en ? (mem_addr_in | index_register) : mem_addr_in;

    assign result_ff = st_ff.result;
    assign result_wr_ff = st_ff.result_wr;
    assign result_addr_ff = st_ff.result_addr;
    assign int_save_word_ff = st_ff.save_word;
    assign int_save_ff = st_ff.save;
    assign general_row_pointer = st_ff.row_ptr;
    assign carry_flag = st_ff.carry;
    assign zero_flag = st_ff.zero;
    assign compare_only_flag = st_ff.compare;
    assign index_enable_flag = st_ff.index_en;
    assign decimal_flag = st_ff.decimal;
    // The nibbles have no fixed-zero bits; other addresses read zero here.

    // =========================================================
    // Assertions
    // =========================================================
    property p_zero_nonzero;
        @(posedge mclk) disable iff (sys_rst)
        (is_arith(op_code) && arith_res != 4'h0 && !mem_wr_en && !int_restore
         && !(op_dest_addr == PSW_ADDR_FLAGS && !compare_only_flag))
        |=> !zero_flag;
    endproperty
    a_zero_nonzero: assert property (p_zero_nonzero) else $error("zero not cleared");

    property p_zero_hold;
        @(posedge mclk) disable iff (sys_rst)
        (is_arith(op_code) && compare_only_flag && arith_res == 4'h0 && !mem_wr_en
         && !int_restore) |=> zero_flag == $past(zero_flag);
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero changed in compare");

    property p_no_wb;
        @(posedge mclk) disable iff (sys_rst)
        (is_arith(op_code) && compare_only_flag) |=> !result_wr_ff;
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("write-back in compare mode");

    property p_bit_test;
        @(posedge mclk) disable iff (sys_rst)
        (op_code == PSW_OP_BIT_TEST && !mem_wr_en && !int_restore) |=> !compare_only_flag;
    endproperty
    a_bit_test: assert property (p_bit_test) else $error("compare not cleared");

    property p_rotate;
        @(posedge mclk) disable iff (sys_rst)
        (op_code == PSW_OP_ROTATE && !mem_wr_en && !int_restore)
        |=> carry_flag == $past(op_a[0]) && result_ff[3] == $past(carry_flag);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate wrong");

    property p_carry_stable;
        @(posedge mclk) disable iff (sys_rst)
        (op_code == PSW_OP_NONE && !mem_wr_en && !int_restore) |=> $stable(carry_flag);
    endproperty
    a_carry_stable: assert property (p_carry_stable) else $error("carry changed");

    property p_reset;
        @(posedge mclk) sys_rst |=> {decimal_flag, compare_only_flag, carry_flag,
                                     zero_flag, index_enable_flag} == 5'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("flags not cleared");

    property p_index;
        @(posedge mclk) disable iff (sys_rst)
        !index_enable_flag |-> real_addr == mem_addr_in;
    endproperty
    a_index: assert property (p_index) else $error("address modified");

    property p_wr_flags;
        @(posedge mclk) disable iff (sys_rst)
        (mem_wr_en && mem_wr_addr == PSW_ADDR_FLAGS && !int_restore)
        |=> mem_rd_addr != PSW_ADDR_FLAGS || mem_rd_data == $past(mem_wr_data);
    endproperty
    a_wr_flags: assert property (p_wr_flags) else $error("flag nibble readback");

    property p_carry_add;
        @(posedge mclk) disable iff (sys_rst)
        (op_code == PSW_OP_ADD && !decimal_flag && !mem_wr_en && !int_restore
         && op_dest_addr != PSW_ADDR_FLAGS)
        |=> carry_flag == $past(({1'b0, op_a} + {1'b0, op_b}) > 5'h0F);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("add carry wrong");

    property p_borrow_sub;
        @(posedge mclk) disable iff (sys_rst)
        (op_code == PSW_OP_SUB && !mem_wr_en && !int_restore
         && op_dest_addr != PSW_ADDR_FLAGS)
        |=> carry_flag == $past(op_a < op_b);
    endproperty
    a_borrow_sub: assert property (p_borrow_sub) else $error("sub borrow wrong");

    property p_overwrite;
        @(posedge mclk) disable iff (sys_rst)
        (is_arith(op_code) && !compare_only_flag && op_dest_addr == PSW_ADDR_FLAGS
         && !mem_wr_en && !int_restore)
        |=> {compare_only_flag, carry_flag, zero_flag, index_enable_flag} == result_ff;
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("flags kept");

    property p_ptr_write;
        @(posedge mclk) disable iff (sys_rst)
        (mem_wr_en && mem_wr_addr == PSW_ADDR_PTR_LOW && !int_restore)
        |=> {general_row_pointer, decimal_flag} == $past(mem_wr_data);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer nibble write");

    property p_index_on;
        @(posedge mclk) disable iff (sys_rst)
        index_enable_flag |-> real_addr == (mem_addr_in | index_register);
    endproperty
    a_index_on: assert property (p_index_on) else $error("address not modified");

    property p_save;
        @(posedge mclk) disable iff (sys_rst)
        int_take |=> int_save_ff && int_save_word_ff == $past({decimal_flag,
            compare_only_flag, carry_flag, zero_flag, index_enable_flag});
    endproperty
    a_save: assert property (p_save) else $error("interrupt save wrong");
endmodule

// File: bench/psw_exec_model.sv
// Purpose: Execution unit stand-in that issues one operation at a time.
// Assumes: The flag logic samples its operation inputs on the rising edge.
// Notes: A gap of idle cycles before an issue models a slow execution unit.
`timescale 1ns/100ps
module psw_exec_model (
    input wire logic mclk,
    output psw_pkg::psw_op_t op_code,
    output logic [3:0] op_a,
    output logic [3:0] op_b,
    output logic [6:0] op_dest_addr
);
    import psw_pkg::*;
    // =========================================================
    // Issue
    initial
    begin
        op_code = PSW_OP_NONE;
        op_a = 4'h0;
        op_b = 4'h0;
        op_dest_addr = 7'h00;
    end
    // Operands are inverted once released, so a stale value never looks valid.
    task automatic issue(input psw_op_t op, input logic [3:0] a, input logic [3:0] b,
                         input logic [6:0] d, input int gap);
        repeat (gap) @(negedge mclk);
        @(negedge mclk);
        op_code = op;
        op_a = a;
        op_b = b;
        op_dest_addr = d;
        @(negedge mclk);
        op_code = PSW_OP_NONE;
        op_a = ~a;
        op_b = ~b;
    endtask
endmodule

// File: bench/program_status_flag_logic_tb.sv
// Purpose: Self-checking bench for the program status flag logic.
// Assumes: Inputs change at the falling edge; results are checked one cycle on.
// Notes: A closing reset at the end of the sequence checks that the flags clear again after use.
`timescale 1ns/100ps
module program_status_flag_logic_tb;
    import psw_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    psw_op_t op_code;
    logic [3:0] op_a, op_b, mem_wr_data, mem_rd_data, result_ff;
    logic [6:0] op_dest_addr, result_addr_ff, real_addr;
    logic [6:0] mem_addr_in = 7'h61;
    logic [6:0] index_register = 7'h12;
    logic [6:0] mem_wr_addr = 7'h00;
    logic [6:0] mem_rd_addr = 7'h00;
    logic mem_wr_en = 1'b0;
    logic int_take = 1'b0;
    logic int_restore = 1'b0;
    logic [4:0] int_restore_word = 5'h00;
    logic mem_rd_hit, result_wr_ff, int_save_ff;
    logic [4:0] int_save_word_ff;
    logic [2:0] general_row_pointer;
    logic carry_flag, zero_flag, compare_only_flag, index_enable_flag, decimal_flag;
    int n_mismatch = 0;
    int n_compared = 0;
    initial mem_wr_data = 4'h0;
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    psw_exec_model i_exec (.mclk(mclk), .op_code(op_code), .op_a(op_a), .op_b(op_b),
        .op_dest_addr(op_dest_addr));
    psw_flag_logic i_dut (.mclk(mclk), .sys_rst(sys_rst), .op_code(op_code),
        .op_a(op_a), .op_b(op_b), .op_dest_addr(op_dest_addr), .mem_addr_in(mem_addr_in),
        .index_register(index_register), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr), .int_take(int_take),
        .int_restore(int_restore), .int_restore_word(int_restore_word),
        .mem_rd_data(mem_rd_data),
        .mem_rd_hit(mem_rd_hit), .result_ff(result_ff), .result_wr_ff(result_wr_ff),
        .result_addr_ff(result_addr_ff), .real_addr(real_addr),
        .int_save_word_ff(int_save_word_ff), .int_save_ff(int_save_ff),
        .general_row_pointer(general_row_pointer), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .compare_only_flag(compare_only_flag),
        .index_enable_flag(index_enable_flag), .decimal_flag(decimal_flag));
    // =========================================================
    // Tasks
    task automatic end_of_test;
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [6:0] s, input logic [6:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        @(negedge mclk);
        mem_wr_en = 1'b1;
        mem_wr_addr = a;
        mem_wr_data = d;
        @(negedge mclk);
        mem_wr_en = 1'b0;
        mem_wr_data = ~d;
    endtask
    task automatic rd(input logic [6:0] a, input logic [3:0] e, input logic hit);
        mem_rd_addr = a;
        #1;
        chk(mem_rd_data, e);
        chk(mem_rd_hit, hit);
    endtask
    // Waits one idle cycle first, so the issue is never back to back.
    task automatic op(input psw_op_t o, input logic [3:0] a, input logic [3:0] b,
                      input logic [3:0] r, input logic c, input logic z, input logic w);
        i_exec.issue(o, a, b, 7'h10, 1);
        chk(result_ff, r);
        chk(carry_flag, c);
        chk(zero_flag, z);
        chk(result_wr_ff, w);
        if (w)
            chk(result_addr_ff, 7'h10);
    endtask
    initial
    begin
        #1000000;
        n_mismatch++;
        end_of_test();
    end
    // =========================================================
    // Sequence
    initial
    begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        rd(7'h7E, 4'h0, 1'b1);
        rd(7'h7F, 4'h0, 1'b1);
        rd(7'h10, 4'h0, 1'b0);
        wr(7'h7F, 4'h5);
        rd(7'h7F, 4'h5, 1'b1);
        chk({carry_flag, index_enable_flag, zero_flag}, 3'b110);
        chk(real_addr, 7'h73);
        wr(7'h7F, 4'h0);
        chk(real_addr, 7'h61);
        wr(7'h7E, 4'hB);
        chk(general_row_pointer, 3'h5);
        chk(decimal_flag, 1'b1);
        rd(7'h7E, 4'hB, 1'b1);
        op(PSW_OP_ADD, 4'h9, 4'h8, 4'h7, 1'b1, 1'b0, 1'b1);
        op(PSW_OP_ROTATE, 4'h4, 4'h0, 4'hA, 1'b0, 1'b0, 1'b1);
        wr(7'h7E, 4'h0);
        op(PSW_OP_ADD, 4'h9, 4'h8, 4'h1, 1'b1, 1'b0, 1'b1);
        op(PSW_OP_SUB, 4'h3, 4'h5, 4'hE, 1'b1, 1'b0, 1'b1);
        op(PSW_OP_ADD, 4'h8, 4'h8, 4'h0, 1'b1, 1'b1, 1'b1);
        op(PSW_OP_ROTATE, 4'h2, 4'h0, 4'h9, 1'b0, 1'b1, 1'b1);
        wr(7'h7F, 4'hA);
        op(PSW_OP_SUB, 4'h5, 4'h5, 4'h0, 1'b0, 1'b1, 1'b0);
        op(PSW_OP_SUB, 4'h5, 4'h6, 4'hF, 1'b1, 1'b0, 1'b0);
        i_exec.issue(PSW_OP_BIT_TEST, 4'h0, 4'h0, 7'h10, 0);
        chk({compare_only_flag, carry_flag, zero_flag}, 3'b010);
        @(negedge mclk);
        int_take = 1'b1;
        @(negedge mclk);
        int_take = 1'b0;
        chk({int_save_ff, int_save_word_ff}, 6'b100100);
        i_exec.issue(PSW_OP_ADD, 4'h8, 4'h8, 7'h7F, 2);
        rd(7'h7F, 4'h0, 1'b1);
        chk(carry_flag, 1'b0);
        wr(7'h7F, 4'h4);
        op(PSW_OP_ADDC, 4'h7, 4'h8, 4'h0, 1'b1, 1'b1, 1'b1);
        op(PSW_OP_SUBC, 4'h5, 4'h5, 4'hF, 1'b1, 1'b0, 1'b1);
        wr(7'h7E, 4'h1);
        op(PSW_OP_SUB, 4'h3, 4'h5, 4'h8, 1'b1, 1'b0, 1'b1);
        @(negedge mclk);
        int_restore = 1'b1;
        int_restore_word = 5'b10110;
        @(negedge mclk);
        int_restore = 1'b0;
        chk({decimal_flag, compare_only_flag, carry_flag, zero_flag, index_enable_flag},
            5'b10110);
        @(negedge mclk);
        sys_rst = 1'b1;
        @(negedge mclk);
        sys_rst = 1'b0;
        chk({decimal_flag, compare_only_flag, carry_flag, zero_flag, index_enable_flag},
            5'h00);
        end_of_test();
    end
endmodule
